// File: sim/prm_pad_model.sv
// pad model: pads follow the block where it drives, else bench levels
`timescale 1ns/1ps

module prm_pad_model (
  // pad side
  input  wire logic [prm_pkg::PIN_N-1:0] pin_out,
  input  wire logic [prm_pkg::PIN_N-1:0] pin_oe,
  input  wire logic [prm_pkg::PIN_N-1:0] ext_level,
  output logic      [prm_pkg::PIN_N-1:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : prm_pad_model

// File: sim/prm_pin_remap_test.sv
// testbench: register access, output placement and input selection
`timescale 1ns/1ps

module prm_pin_remap_test;
  logic                     clk;
  logic                     rst;
  logic [3:0]               avs_address;
  logic                     avs_read;
  logic                     avs_write;
  logic [31:0]              avs_writedata;
  logic [3:0]               avs_byteenable;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  prm_pkg::prm_periph_out_t periph_out;
  prm_pkg::prm_periph_in_t  periph_in;
  logic [55:0]              pin_in;
  logic [55:0]              pin_out;
  logic [55:0]              pin_oe;
  logic [55:0]              ext_level;
  logic [55:0]              pin_func;
  logic [55:0]              pin_out_s;
  logic [31:0]              rdata;
  int                       error_cnt;
  int                       tests_run;

  prm_pin_remap i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .periph_out(periph_out), .periph_in(periph_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_func(pin_func));

  // smallest variant on the same bus, pads straight from bench levels
  prm_pin_remap #(.VARIANT(prm_pkg::VAR_SMALL)) i_small (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .periph_out(periph_out), .periph_in(), .pin_in(ext_level),
    .pin_out(pin_out_s), .pin_oe(), .pin_func());

  prm_pad_model i_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [55:0] exp, input logic [55:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : acc

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk("readdata", {48'h0, exp}, {24'h0, rdata});
  endtask : rd_chk

  task automatic pin_chk(input logic [3:0] a, input logic [7:0] v, input logic [19:0] po,
                         input logic [55:0] exp);
    acc(1'b1, a, v);
    periph_out <= prm_pkg::prm_periph_out_t'(po);
    repeat (3) @(posedge clk);
    chk("pin_out", exp, pin_out);
  endtask : pin_chk

  task automatic in_chk(input logic [7:0] v, input int p, input logic [9:0] exp);
    acc(1'b1, 4'h4, v);
    ext_level <= 56'h1 << p;
    repeat (8) @(posedge clk);
    chk("periph_in", {46'h0, exp}, {46'h0, periph_in});
  endtask : in_chk

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    periph_out = '0;
    ext_level = 56'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h4, 8'h00);
    rd_chk(4'h8, 8'h00);
    chk("pin_func", 56'h93C20E3, pin_func);
    pin_chk(4'h0, 8'h00, 20'h80000, 56'h1 << 18);
    pin_chk(4'h0, 8'h01, 20'h80000, 56'h1 << 21);
    pin_chk(4'h0, 8'h00, 20'h40000, 56'h1 << 5);
    pin_chk(4'h0, 8'h02, 20'h40000, 56'h1 << 27);
    pin_chk(4'h0, 8'h04, 20'h40000, 56'h1 << 14);
    pin_chk(4'h0, 8'h06, 20'h40020, 56'h1 << 25);
    chk("small pin_out", 56'h1 << 17 | 56'h1 << 7, pin_out_s);
    acc(1'b1, 4'h8, 8'h10);
    pin_chk(4'h0, 8'h0A, 20'h00008, 56'h1 << 15);
    pin_chk(4'h0, 8'h80, 20'h00400, 56'h1 << 49);
    pin_chk(4'h0, 8'h40, 20'h00400, 56'h1 << 41);
    pin_chk(4'h0, 8'hC0, 20'h00400, 56'h0);
    pin_chk(4'h0, 8'h20, 20'h00800, 56'h1 << 48);
    pin_chk(4'h8, 8'h80, 20'h00001, 56'h1 << 35);
    pin_chk(4'h8, 8'h40, 20'h00002, 56'h1 << 37);
    pin_chk(4'h8, 8'h20, 20'h00004, 56'h1 << 28);
    pin_chk(4'h8, 8'h08, 20'h00010, 56'h1 << 36);
    pin_chk(4'h8, 8'h04, 20'h00080, 56'h1 << 23);
    pin_chk(4'h8, 8'h02, 20'h00100, 56'h1 << 29);
    pin_chk(4'h8, 8'h01, 20'h00200, 56'h1 << 22);
    pin_chk(4'h0, 8'h00, 20'h00000, 56'h0);
    in_chk(8'h02, 32, 10'h004);
    in_chk(8'h0C, 39, 10'h002);
    in_chk(8'h10, 34, 10'h001);
    in_chk(8'h20, 26, 10'h020);
    acc(1'b1, 4'h4, 8'hA5);
    rd_chk(4'h4, 8'hA5);
    final_report();
  end
endmodule : prm_pin_remap_test

// File: verilog/prm_pin_remap.sv
// top: pin remapping multiplexer with its register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - clock-pin bit: clock out and int in on C2/C3, or C5/C4 when set
// - serial code 00 uses A5,A6,A7,B5; code 01 uses D3,D2,D1,D0
// - serial code 10 uses B6, B7, D6, D7
// - serial code 11 uses D1,D2,D3,D0 on largest part, else undefined
// - smallest part: single serial bit moves lines to C1,C0,C7,C6
// - smallest part: port C bit with serial bit moves timer1 B0/B1 to A6/A7
// - port D bit with serial 01 (or 11 largest) moves D0..D3 functions
// - comparator1 output on A5, F1 or G1; mid parts A5 or F1
// - comparator0 output on A0, F0 or G0; mid parts A0 or F0
// - timer clock inputs: timer2 C2/D0, timer1 A4/D3, timer0 A2/D2
// - largest part: interrupt 2 input on C4 or E2
// - interrupt 1 input on A4, C5, E1 (largest only) or E7
// - interrupt 0 input on A3, C4, E0 (largest only) or E6
// - timer1 outputs: B2 on C5/E4, A on A1/C7
// - absent register bits ignore writes and read zero
module prm_pin_remap #(
  parameter prm_pkg::prm_variant_t VARIANT = prm_pkg::VAR_LARGE
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // avalon-mm slave
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // peripheral side
  input  wire prm_pkg::prm_periph_out_t    periph_out,
  output prm_pkg::prm_periph_in_t          periph_in,
  // pad side
  input  wire logic [prm_pkg::PIN_N-1:0]   pin_in,
  output logic      [prm_pkg::PIN_N-1:0]   pin_out,
  output logic      [prm_pkg::PIN_N-1:0]   pin_oe,
  output logic      [prm_pkg::PIN_N-1:0]   pin_func
);

  localparam int NOUT = 17;
  localparam int NIN  = 10;
  localparam int pa   = prm_pkg::PORT_A;
  localparam int pb   = prm_pkg::PORT_B;
  localparam int pc   = prm_pkg::PORT_C;
  localparam int pd   = prm_pkg::PORT_D;
  localparam int pe   = prm_pkg::PORT_E;
  localparam int pf   = prm_pkg::PORT_F;
  localparam int pg   = prm_pkg::PORT_G;
  localparam prm_pkg::prm_pin_t none = prm_pkg::PIN_NONE;
  localparam logic is_small = (VARIANT == prm_pkg::VAR_SMALL);
  localparam logic is_large = (VARIANT == prm_pkg::VAR_LARGE);
  localparam logic has_t3   = (VARIANT == prm_pkg::VAR_MID_T3) || is_large;

  function automatic prm_pkg::prm_pin_t at(input int p, input int b);
    at = prm_pkg::prm_pin_t'(p * prm_pkg::PORT_W + b);
  endfunction : at

  prm_pkg::prm_serial_comp_t rs0;
  prm_pkg::prm_clk_irq_t     rs1;
  prm_pkg::prm_timer_out_t   rs2;
  prm_pkg::prm_status_t      undef_next;
  prm_pkg::prm_status_t      status_reg;
  prm_pkg::prm_periph_in_t   periph_in_reg;
  prm_pkg::prm_periph_in_t   periph_in_next;
  logic [prm_pkg::PIN_N-1:0] s1_reg;
  logic [prm_pkg::PIN_N-1:0] s2_reg;
  logic [prm_pkg::PIN_N-1:0] s3_reg;
  logic [prm_pkg::PIN_N-1:0] pin_s_reg;
  logic [prm_pkg::PIN_N-1:0] pin_out_reg;
  logic [prm_pkg::PIN_N-1:0] pin_oe_reg;
  logic [prm_pkg::PIN_N-1:0] pin_func_reg;
  logic [prm_pkg::PIN_N-1:0] out_next;
  logic [prm_pkg::PIN_N-1:0] oe_next;
  logic [prm_pkg::PIN_N-1:0] func_next;
  logic [1:0]                ser_code;
  logic                      pd_on;
  logic                      pc_on;
  prm_pkg::prm_pin_t sdo_idx, sda_idx, sck_idx, ssel_idx, pclk_idx, pirq_idx;
  prm_pkg::prm_pin_t cmp0_idx, cmp1_idx, tclk0_idx, tclk1_idx, tclk2_idx;
  prm_pkg::prm_pin_t irq0_idx, irq1_idx, irq2_idx;
  prm_pkg::prm_pin_t t0o0_idx, t0o1_idx, t1a_idx, t1b0_idx, t1b1_idx, t1b2_idx;
  prm_pkg::prm_pin_t t2o0_idx, t2o1_idx, t3o0_idx, t3o1_idx;
  prm_pkg::prm_pin_t o_idx [NOUT];
  prm_pkg::prm_pin_t i_idx [NIN];
  logic [NOUT-1:0]   o_val;
  logic [NOUT-1:0]   o_en;
  logic [NIN-1:0]    i_val;

  assign pin_out   = pin_out_reg;
  assign pin_oe    = pin_oe_reg;
  assign pin_func  = pin_func_reg;
  assign periph_in = periph_in_reg;

  prm_regs #(
    .VARIANT (VARIANT)
  ) u_regs (
    .clk             (clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .status          (status_reg),
    .serial_comp     (rs0),
    .clk_irq         (rs1),
    .timer_out       (rs2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      pin_s_reg <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      pin_s_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (pin_s_reg & (s2_reg ^ s3_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin choice for every relocatable signal
  always_comb begin
    undef_next = '0;
    ser_code   = {rs0.serial_pin_sel_hi, rs0.serial_pin_sel_lo};
    sdo_idx    = at(pa, 5);
    sda_idx    = at(pa, 6);
    sck_idx    = at(pa, 7);
    ssel_idx   = at(pb, 5);
    if (is_small) begin
      if (rs0.serial_pin_sel_lo) begin
        sdo_idx = at(pc, 1);
        sda_idx = at(pc, 0);
        sck_idx = at(pc, 7);
        ssel_idx = at(pc, 6);
      end
    end else begin
      unique case (ser_code)
        2'h0: ;
        2'h1: begin
          sdo_idx = at(pd, 3);
          sda_idx = at(pd, 2);
          sck_idx = at(pd, 1);
          ssel_idx = at(pd, 0);
        end
        2'h2: begin
          sdo_idx = at(pb, 6);
          sda_idx = at(pb, 7);
          sck_idx = at(pd, 6);
          ssel_idx = at(pd, 7);
        end
        2'h3: begin
          if (is_large) begin
            sdo_idx = at(pd, 1);
            sda_idx = at(pd, 2);
            sck_idx = at(pd, 3);
            ssel_idx = at(pd, 0);
          end else begin
            sdo_idx = none;
            sda_idx = none;
            sck_idx = none;
            ssel_idx = none;
            undef_next.undef_serial = 1'h1;
          end
        end
      endcase
    end
    // on the smallest part bit 2 is the port C remap bit
    pc_on = is_small && rs0.serial_pin_sel_hi && rs0.serial_pin_sel_lo;
    pd_on = !is_small && rs0.portd_remap_sel &&
            (ser_code == 2'h1 || (ser_code == 2'h3 && is_large));
    pclk_idx = rs0.periph_clock_pin_sel ? at(pc, 5) : at(pc, 2);
    pirq_idx = rs0.periph_clock_pin_sel ? at(pc, 4) : at(pc, 3);
    if (is_large) begin
      unique case ({rs0.comparator1_pin_sel_hi, rs0.comparator1_pin_sel_lo})
        2'h0: cmp1_idx = at(pa, 5);
        2'h1: cmp1_idx = at(pf, 1);
        2'h2: cmp1_idx = at(pg, 1);
        2'h3: begin
          cmp1_idx = none;
          undef_next.undef_cmp1 = 1'h1;
        end
      endcase
      unique case ({rs0.comparator0_pin_sel_hi, rs0.comparator0_pin_sel_lo})
        2'h0: cmp0_idx = at(pa, 0);
        2'h1: cmp0_idx = at(pf, 0);
        2'h2: cmp0_idx = at(pg, 0);
        2'h3: begin
          cmp0_idx = none;
          undef_next.undef_cmp0 = 1'h1;
        end
      endcase
    end else begin
      cmp1_idx = rs0.comparator1_pin_sel_lo ? at(pf, 1) : at(pa, 5);
      cmp0_idx = rs0.comparator0_pin_sel_lo ? at(pf, 0) : at(pa, 0);
    end
    tclk2_idx = is_small ? none : !rs1.timer2_clock_pin_sel ? at(pc, 2) :
                pd_on ? at(pb, 6) : at(pd, 0);
    tclk1_idx = !rs1.timer1_clock_pin_sel ? at(pa, 4) : pd_on ? at(pd, 7) : at(pd, 3);
    tclk0_idx = !rs1.timer0_clock_pin_sel ? at(pa, 2) : pd_on ? at(pd, 6) : at(pd, 2);
    irq2_idx = !is_large ? none : rs1.ext_irq2_pin_sel ? at(pe, 2) : at(pc, 4);
    unique case ({rs1.ext_irq1_pin_sel_hi, rs1.ext_irq1_pin_sel_lo})
      2'h0: irq1_idx = at(pa, 4);
      2'h1: irq1_idx = at(pc, 5);
      2'h2: begin
        irq1_idx = is_large ? at(pe, 1) : none;
        undef_next.undef_irq1 = !is_large;
      end
      2'h3: irq1_idx = at(pe, 7);
    endcase
    unique case ({rs1.ext_irq0_pin_sel_hi, rs1.ext_irq0_pin_sel_lo})
      2'h0: irq0_idx = at(pa, 3);
      2'h1: irq0_idx = at(pc, 4);
      2'h2: begin
        irq0_idx = is_large ? at(pe, 0) : none;
        undef_next.undef_irq0 = !is_large;
      end
      2'h3: irq0_idx = at(pe, 6);
    endcase
    t3o1_idx = !has_t3 ? none : rs2.timer3_out1_pin_sel ? at(pe, 3) : at(pd, 0);
    t3o0_idx = !has_t3 ? none : rs2.timer3_out0_pin_sel ? at(pe, 5) : at(pd, 3);
    t2o1_idx = is_small ? none : rs2.timer2_out1_pin_sel ? at(pd, 4) : at(pc, 4);
    t2o0_idx = is_small ? none : !rs2.timer2_out0_pin_sel ? at(pc, 3) :
               pd_on ? at(pb, 7) : at(pd, 1);
    t1b2_idx = rs2.timer1_outb2_pin_sel ? at(pe, 4) : at(pc, 5);
    t1a_idx  = rs2.timer1_outa_pin_sel ? at(pc, 7) : at(pa, 1);
    t0o1_idx = rs2.timer0_out1_pin_sel ? at(pd, 5) : at(pc, 5);
    t0o0_idx = rs2.timer0_out0_pin_sel ? at(pc, 6) : at(pa, 0);
    t1b0_idx = !is_small ? none : pc_on ? at(pa, 6) : at(pc, 0);
    t1b1_idx = !is_small ? none : pc_on ? at(pa, 7) : at(pc, 1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // output list, lowest priority first: a later entry owns a shared pin
  assign o_idx = '{t3o1_idx, t3o0_idx, t2o1_idx, t2o0_idx, t1b2_idx, t1a_idx,
                   t0o1_idx, t0o0_idx, t1b0_idx, t1b1_idx, cmp0_idx, cmp1_idx,
                   pclk_idx, ssel_idx, sck_idx, sda_idx, sdo_idx};
  assign o_val = {periph_out.sdo, periph_out.sda_o, periph_out.sck_o,
                  periph_out.ssel_o, periph_out.peripheral_clock_out,
                  periph_out.comparator1_out, periph_out.comparator0_out,
                  periph_out.timer1_out_b1, periph_out.timer1_out_b0,
                  periph_out.timer0_out0, periph_out.timer0_out1,
                  periph_out.timer1_out_a, periph_out.timer1_out_b2,
                  periph_out.timer2_out0, periph_out.timer2_out1,
                  periph_out.timer3_out0, periph_out.timer3_out1};
  assign o_en  = {1'h1, periph_out.sda_oe, periph_out.sck_oe, periph_out.ssel_oe,
                  13'h1FFF};
  assign i_idx = '{pirq_idx, sda_idx, sck_idx, ssel_idx, tclk0_idx, tclk1_idx,
                   tclk2_idx, irq0_idx, irq1_idx, irq2_idx};

  always_comb begin
    out_next  = '0;
    oe_next   = '0;
    func_next = '0;
    for (int k = 0; k < NOUT; k++) begin
      if (o_idx[k] != none) begin
        out_next[o_idx[k]]  = o_val[k];
        oe_next[o_idx[k]]   = o_en[k];
        func_next[o_idx[k]] = 1'h1;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NIN; k++) begin
      i_val[NIN-1-k] = (i_idx[k] != none) ? pin_s_reg[i_idx[k]] : 1'h0;
    end
    periph_in_next = i_val;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_reg   <= '0;
      pin_oe_reg    <= '0;
      pin_func_reg  <= '0;
      periph_in_reg <= '0;
      status_reg    <= '0;
    end else begin
      pin_out_reg   <= out_next;
      pin_oe_reg    <= oe_next;
      pin_func_reg  <= func_next;
      periph_in_reg <= periph_in_next;
      status_reg    <= undef_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_placed(prm_pkg::prm_pin_t idx, logic v);
    pin_func_reg[idx] && pin_out_reg[idx] == v;
  endsequence

  pclk_route_a:
    assert property (rs0.periph_clock_pin_sel |=>
      s_placed(at(pc, 5), $past(periph_out.peripheral_clock_out)) and
      periph_in_reg.peripheral_int_in == $past(pin_s_reg[at(pc, 4)]))
    else $error("clock select 1 did not reach C5/C4");

  serial_low_a:
    assert property (!is_small && ser_code == 2'h1 |->
      sdo_idx == at(pd, 3) && sck_idx == at(pd, 1) && ssel_idx == at(pd, 0) ##1
      s_placed(at(pd, 3), $past(periph_out.sdo)))
    else $error("serial code 01 not on port D");

  serial_alt_a:
    assert property (!is_small && ser_code == 2'h2 |->
      sda_idx == at(pb, 7) && sck_idx == at(pd, 6) ##1
      s_placed(at(pb, 6), $past(periph_out.sdo)))
    else $error("serial code 10 misplaced");

  serial_top_a:
    assert property (!is_small && ser_code == 2'h3 |=>
      status_reg.undef_serial == !is_large &&
      $past(sdo_idx) == (is_large ? at(pd, 1) : none))
    else $error("serial code 11 handled wrongly");

  serial_small_a:
    assert property (is_small && rs0.serial_pin_sel_lo |=>
      s_placed(at(pc, 1), $past(periph_out.sdo)) and $past(ssel_idx) == at(pc, 6))
    else $error("small serial select not on port C");

  portc_move_a:
    assert property (is_small && rs0.serial_pin_sel_hi && rs0.serial_pin_sel_lo |=>
      s_placed(at(pa, 7), $past(periph_out.timer1_out_b1)))
    else $error("timer1 B1 did not move to A7");

  portd_move_a:
    assert property (pd_on && rs1.timer2_clock_pin_sel |=>
      periph_in_reg.timer2_clock_in == $past(pin_s_reg[at(pb, 6)]))
    else $error("timer2 clock did not move to B6");

  comp_route_a:
    assert property (is_large && rs0.comparator1_pin_sel_hi &&
      !rs0.comparator1_pin_sel_lo |=>
      s_placed(at(pg, 1), $past(periph_out.comparator1_out)))
    else $error("comparator1 code 10 not on G1");

  tck_route_a:
    assert property (!rs1.timer0_clock_pin_sel |->
      tclk0_idx == at(pa, 2) ##1
      periph_in_reg.timer0_clock_in == $past(pin_s_reg[at(pa, 2)]))
    else $error("timer0 clock not taken from A2");

  irq_route_a:
    assert property (rs1.ext_irq0_pin_sel_hi && rs1.ext_irq0_pin_sel_lo |=>
      periph_in_reg.ext_irq0_in == $past(pin_s_reg[at(pe, 6)]))
    else $error("interrupt 0 code 11 not from E6");

  tmr_out_a:
    assert property (rs2.timer1_outa_pin_sel |=>
      s_placed(at(pc, 7), $past(periph_out.timer1_out_a)) and
      $past(t0o1_idx) == ($past(rs2.timer0_out1_pin_sel) ? at(pd, 5) : at(pc, 5)))
    else $error("timer output placement wrong");

  unimpl_zero_a:
    assert property ((rs0 & ~prm_pkg::MASK_SERIAL_COMP[VARIANT]) == 8'h00 &&
      (rs1 & ~prm_pkg::MASK_CLK_IRQ[VARIANT]) == 8'h00 &&
      (rs2 & ~prm_pkg::MASK_TIMER_OUT[VARIANT]) == 8'h00)
    else $error("absent remap bit holds a one");

  reset_clear_a:
    assert property (@(posedge clk) disable iff (1'b0) rst |=>
      rs0 == 8'h00 && rs1 == 8'h00 && rs2 == 8'h00 && pin_func_reg == '0)
    else $error("remap bits not cleared by reset");

endmodule : prm_pin_remap

// File: verilog/prm_pkg.sv
// package: remap register layouts, offsets, write masks and carriers
package prm_pkg;

  localparam int PORT_W = 8;
  localparam int PORT_N = 7;
  localparam int PIN_N  = PORT_W * PORT_N;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;

  typedef logic [5:0] prm_pin_t;
  localparam prm_pin_t PIN_NONE = 6'h3F;

  localparam logic [3:0] OFS_SERIAL_COMP = 4'h0;
  localparam logic [3:0] OFS_CLK_IRQ     = 4'h4;
  localparam logic [3:0] OFS_TIMER_OUT   = 4'h8;
  localparam logic [3:0] OFS_STATUS      = 4'hC;
  localparam logic [7:0] REG_RESET       = 8'h00;

  typedef enum logic [1:0] {
    VAR_SMALL  = 2'h0,
    VAR_MID    = 2'h1,
    VAR_MID_T3 = 2'h2,
    VAR_LARGE  = 2'h3
  } prm_variant_t;

  // implemented bits per variant, indexed by prm_variant_t
  localparam logic [3:0][7:0] MASK_SERIAL_COMP = {8'hFF, 8'h5F, 8'h5F, 8'h07};
  localparam logic [3:0][7:0] MASK_CLK_IRQ     = {8'hFF, 8'hEF, 8'hEF, 8'h00};
  localparam logic [3:0][7:0] MASK_TIMER_OUT   = {8'hFF, 8'hFF, 8'h3F, 8'h00};

  typedef struct packed {
    logic comparator1_pin_sel_hi;
    logic comparator1_pin_sel_lo;
    logic comparator0_pin_sel_hi;
    logic comparator0_pin_sel_lo;
    logic portd_remap_sel;
    logic serial_pin_sel_hi;
    logic serial_pin_sel_lo;
    logic periph_clock_pin_sel;
  } prm_serial_comp_t;

  typedef struct packed {
    logic timer2_clock_pin_sel;
    logic timer1_clock_pin_sel;
    logic timer0_clock_pin_sel;
    logic ext_irq2_pin_sel;
    logic ext_irq1_pin_sel_hi;
    logic ext_irq1_pin_sel_lo;
    logic ext_irq0_pin_sel_hi;
    logic ext_irq0_pin_sel_lo;
  } prm_clk_irq_t;

  typedef struct packed {
    logic timer3_out1_pin_sel;
    logic timer3_out0_pin_sel;
    logic timer2_out1_pin_sel;
    logic timer2_out0_pin_sel;
    logic timer1_outb2_pin_sel;
    logic timer1_outa_pin_sel;
    logic timer0_out1_pin_sel;
    logic timer0_out0_pin_sel;
  } prm_timer_out_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       undef_irq0;
    logic       undef_irq1;
    logic       undef_cmp0;
    logic       undef_cmp1;
    logic       undef_serial;
  } prm_status_t;

  typedef struct packed {
    logic peripheral_clock_out;
    logic sdo;
    logic sda_o;
    logic sda_oe;
    logic sck_o;
    logic sck_oe;
    logic ssel_o;
    logic ssel_oe;
    logic comparator0_out;
    logic comparator1_out;
    logic timer0_out0;
    logic timer0_out1;
    logic timer1_out_a;
    logic timer1_out_b0;
    logic timer1_out_b1;
    logic timer1_out_b2;
    logic timer2_out0;
    logic timer2_out1;
    logic timer3_out0;
    logic timer3_out1;
  } prm_periph_out_t;

  typedef struct packed {
    logic peripheral_int_in;
    logic sdi_sda;
    logic sck_scl;
    logic serial_select;
    logic timer0_clock_in;
    logic timer1_clock_in;
    logic timer2_clock_in;
    logic ext_irq0_in;
    logic ext_irq1_in;
    logic ext_irq2_in;
  } prm_periph_in_t;

endpackage : prm_pkg

// File: verilog/prm_regs.sv
// module: avalon-mm slave holding the three remap registers and status
`timescale 1ns/1ps

module prm_regs #(
  parameter prm_pkg::prm_variant_t VARIANT = prm_pkg::VAR_LARGE
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // avalon-mm slave
  input  wire logic [3:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // block state and register contents
  input  wire logic [7:0]                status,
  output prm_pkg::prm_serial_comp_t      serial_comp,
  output prm_pkg::prm_clk_irq_t          clk_irq,
  output prm_pkg::prm_timer_out_t        timer_out
);

  logic                      wait_reg;
  logic [31:0]               readdata_reg;
  prm_pkg::prm_serial_comp_t serial_comp_reg;
  prm_pkg::prm_clk_irq_t     clk_irq_reg;
  prm_pkg::prm_timer_out_t   timer_out_reg;
  logic [7:0]                rd_next;
  logic                      wr_take;

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = readdata_reg;
  assign serial_comp     = serial_comp_reg;
  assign clk_irq         = clk_irq_reg;
  assign timer_out       = timer_out_reg;
  assign wr_take         = avs_write && !wait_reg && avs_byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle on every access, then the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'h1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end

  always_comb begin
    unique case (avs_address)
      prm_pkg::OFS_SERIAL_COMP: rd_next = serial_comp_reg;
      prm_pkg::OFS_CLK_IRQ:     rd_next = clk_irq_reg;
      prm_pkg::OFS_TIMER_OUT:   rd_next = timer_out_reg;
      prm_pkg::OFS_STATUS:      rd_next = status;
      default:                  rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      readdata_reg <= {24'h00_0000, rd_next};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // absent bits never store, so they read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_comp_reg <= prm_pkg::REG_RESET;
      clk_irq_reg     <= prm_pkg::REG_RESET;
      timer_out_reg   <= prm_pkg::REG_RESET;
    end else if (wr_take) begin
      unique case (avs_address)
        prm_pkg::OFS_SERIAL_COMP:
          serial_comp_reg <= avs_writedata[7:0] & prm_pkg::MASK_SERIAL_COMP[VARIANT];
        prm_pkg::OFS_CLK_IRQ:
          clk_irq_reg <= avs_writedata[7:0] & prm_pkg::MASK_CLK_IRQ[VARIANT];
        prm_pkg::OFS_TIMER_OUT:
          timer_out_reg <= avs_writedata[7:0] & prm_pkg::MASK_TIMER_OUT[VARIANT];
        default: ;
      endcase
    end
  end

endmodule : prm_regs
